// ==== rtl/pmrc_map.vh ====
`ifndef PMRC_MAP_VH
`define PMRC_MAP_VH
// oscillator periods of reset hold needed before a full reset
`define PMRC_RST_OSC_PERIODS 24
// reset qualification counter width
`define PMRC_RST_CNT_W 5
// machine cycles of the reset-ends-idle window
`define PMRC_IDLE_RST_MC 2
// oscillator periods in one machine cycle
`define PMRC_OSC_PER_MC 12
// window length in oscillator periods
`define PMRC_IDLE_RST_OSC 24
// last count of the reset qualification counter
`define PMRC_RST_LAST 5'h17
// last count of the ram-block window counter
`define PMRC_WIN_LAST 5'h17
// wake-enable bit position in auxiliary control one
`define PMRC_WAKE_EN_BIT 3
// mode encodings
`define PMRC_MODE_RUN 2'h0
`define PMRC_MODE_IDLE 2'h1
`define PMRC_MODE_PD 2'h2
`define PMRC_MODE_EMU 2'h3
`endif

// ==== rtl/pmrc_sync.v ====
`timescale 1ns/1ns
// three-stage synchroniser; output changes when stages two and three agree
module pmrc_sync #(
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input  wire i_sys_clk,
   input  wire i_rst,
   // async input and filtered result
   input  wire i_async,
   output reg  o_sync
);
   reg [2:0] stage_ff;

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         stage_ff <= {3{RST_VAL}};
         o_sync   <= RST_VAL;
      end else begin
         stage_ff <= {stage_ff[1:0], i_async};
         if (stage_ff[1] == stage_ff[2]) begin
            o_sync <= stage_ff[2];
         end
      end
   end
endmodule // pmrc_sync

// ==== rtl/pmrc_top.v ====
// Functional notes
// R01: reset pin high for 24 oscillator periods while running causes a full reset.
// R02: internal clock is the oscillator halved by a toggle flip-flop.
// R03: ram and register state are kept while the clock is slowed or stopped.
// R04: idle request halts the processor after the instruction; peripherals keep running.
// R05: enabled interrupt leaves idle into its handler; reset restarts as power-on.
// R06: power-down request stops the oscillator after the requesting instruction.
// R07: reset exit from power-down reinitialises registers but keeps ram.
// R08: interrupt wake from power-down only when wake-enable bit 3 is one.
// R09: wake source must stay active until the oscillator restarts, under 10 ms.
// R10: wake needs enabled level interrupt; low restarts oscillator, high completes exit.
// R11: after the wake handler returns, execution continues after the power-down instruction.
// R12: variant without program memory always allows interrupt wake from power-down.
// R13: reset ending idle blocks ram access for up to two machine cycles.
// R14: address strobe low in reset with program strobe high enters emulation float.
// R15: emulation float: port 0 floats, rest pulled weakly high, oscillator runs.
// R16: idle drives strobes high, power-down low; port 0 floats with external memory.
// R17: mode requests come from control bits; power-down wins; bits clear on exit.
`timescale 1ns/1ns
`include "pmrc_map.vh"
module pmrc_top (
   // clock and reset
   input  wire       i_sys_clk,
   input  wire       i_rst,
   // oscillator enable pulse and pins
   input  wire       i_osc_tick,
   input  wire       i_reset_pin,
   input  wire       i_ext_irq_zero_n,
   input  wire       i_ext_irq_one_n,
   input  wire       i_addr_strobe_pin,
   input  wire       i_program_store_strobe_pin,
   // configuration
   input  wire       i_irq_zero_en,
   input  wire       i_irq_one_en,
   input  wire       i_irq_zero_level,
   input  wire       i_irq_one_level,
   input  wire [7:0] i_aux_control_one,
   input  wire       i_romless,
   input  wire       i_ext_prog_mem,
   input  wire       i_any_irq_pending,
   // control bit writes and instruction boundary
   input  wire       i_set_idle_req,
   input  wire       i_set_pd_req,
   input  wire       i_instr_done,
   // status and control outputs
   output reg        o_idle_req,
   output reg        o_pd_req,
   output reg  [1:0] o_mode,
   output reg        o_int_clk_en,
   output reg        o_cpu_clk_en,
   output reg        o_periph_clk_en,
   output reg        o_osc_run,
   output reg        o_full_reset,
   output reg        o_sfr_reset,
   output reg        o_ram_block,
   output reg        o_wake_irq,
   // pin control
   output reg        o_addr_strobe_val,
   output reg        o_program_store_strobe_val,
   output reg        o_strobe_force,
   output reg        o_port0_float,
   output reg        o_weak_pullup,
   output reg        o_port2_addr
);
   wire       rst_s;
   wire       irq0_s;
   wire       irq1_s;
   wire       ale_s;
   wire       program_store_strobe_s;
   reg  [4:0] rst_cnt_ff;
   reg  [4:0] win_cnt_ff;
   reg        win_ff;
   reg        half_ff;
   reg        waking_ff;
   reg        emu_arm_ff;
   wire       wake_en;
   wire       lvl_low;
   wire       rst_qual;

   pmrc_sync #(.RST_VAL(1'b0)) u_rst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_async(i_reset_pin), .o_sync(rst_s));
   pmrc_sync #(.RST_VAL(1'b1)) u_i0 (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_async(i_ext_irq_zero_n), .o_sync(irq0_s));
   pmrc_sync #(.RST_VAL(1'b1)) u_i1 (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_async(i_ext_irq_one_n), .o_sync(irq1_s));
   pmrc_sync #(.RST_VAL(1'b1)) u_al (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_async(i_addr_strobe_pin), .o_sync(ale_s));
   pmrc_sync #(.RST_VAL(1'b1)) u_ps (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_async(i_program_store_strobe_pin), .o_sync(program_store_strobe_s));

   assign wake_en  = i_aux_control_one[`PMRC_WAKE_EN_BIT] | i_romless; // R08 R12
   // R10
   assign lvl_low  = (i_irq_zero_en & i_irq_zero_level & ~irq0_s) |
                     (i_irq_one_en & i_irq_one_level & ~irq1_s);
   assign rst_qual = rst_s & (rst_cnt_ff == `PMRC_RST_LAST) & i_osc_tick; // R01

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         rst_cnt_ff   <= 5'h00;
         win_cnt_ff   <= 5'h00;
         win_ff       <= 1'b0;
         half_ff      <= 1'b0;
         waking_ff    <= 1'b0;
         emu_arm_ff   <= 1'b0;
         o_idle_req   <= 1'b0;
         o_pd_req     <= 1'b0;
         o_mode       <= `PMRC_MODE_RUN;
         o_int_clk_en <= 1'b0;
         o_cpu_clk_en <= 1'b0;
         o_periph_clk_en <= 1'b0;
         o_osc_run    <= 1'b1;
         o_full_reset <= 1'b1;
         o_sfr_reset  <= 1'b1;
         o_ram_block  <= 1'b0;
         o_wake_irq   <= 1'b0;
         o_addr_strobe_val <= 1'b1;
         o_program_store_strobe_val <= 1'b1;
         o_strobe_force <= 1'b0;
         o_port0_float  <= 1'b0;
         o_weak_pullup  <= 1'b0;
         o_port2_addr   <= 1'b0;
      end else begin
         o_wake_irq <= 1'b0;
         // qualify reset over oscillator periods; counts only while oscillator runs
         if (!rst_s) begin
            rst_cnt_ff <= 5'h00;
         end else if (i_osc_tick && o_osc_run && !rst_qual) begin
            rst_cnt_ff <= rst_cnt_ff + 5'h01;
         end
         // R02: toggle divider gives the internal clock enable
         if (i_osc_tick && o_osc_run) begin
            half_ff <= ~half_ff;
         end
         o_int_clk_en <= i_osc_tick & o_osc_run & half_ff; // R02
         // R13: window after reset ends idle
         if (win_ff && i_osc_tick) begin
            if (win_cnt_ff == `PMRC_WIN_LAST) begin
               win_ff      <= 1'b0;
               o_ram_block <= 1'b0; // R13
            end
            win_cnt_ff <= win_cnt_ff + 5'h01;
         end
         if (rst_qual && o_osc_run) begin
            // R01 R05 R07: full reset; ram is outside this block and untouched
            o_full_reset <= 1'b1;
            o_sfr_reset  <= 1'b1;
            o_idle_req   <= 1'b0;
            o_pd_req     <= 1'b0;
            o_mode       <= `PMRC_MODE_RUN;
            emu_arm_ff   <= ~ale_s & program_store_strobe_s; // R14
         end else if (o_full_reset && !rst_s) begin
            o_full_reset <= 1'b0;
            o_sfr_reset  <= 1'b0;
            win_ff       <= 1'b0;
            o_ram_block  <= 1'b0;
            // R14 R15: strobe still low at release enters emulation float
            if (emu_arm_ff && !ale_s) begin
               o_mode <= `PMRC_MODE_EMU;
            end
            emu_arm_ff <= 1'b0;
         end else if (o_full_reset) begin
            emu_arm_ff <= ~ale_s & program_store_strobe_s; // R14
         end else begin
            // R17: power-down takes precedence at the boundary
            case (o_mode)
               `PMRC_MODE_RUN: begin
                  // R04 R06: enter at the instruction boundary
                  if (i_instr_done && (o_pd_req || i_set_pd_req)) begin
                     o_mode <= `PMRC_MODE_PD;
                  end else if (i_instr_done && (o_idle_req || i_set_idle_req)) begin
                     o_mode <= `PMRC_MODE_IDLE;
                  end
               end
               `PMRC_MODE_IDLE: begin
                  if (rst_s && !win_ff) begin
                     win_ff      <= 1'b1; // R13
                     win_cnt_ff  <= 5'h00;
                     o_ram_block <= 1'b1; // R13
                  end else if (i_any_irq_pending && !rst_s) begin
                     o_mode     <= `PMRC_MODE_RUN; // R05
                     o_idle_req <= 1'b0; // R17
                     o_wake_irq <= 1'b1; // R05
                  end
               end
               `PMRC_MODE_PD: begin
                  if (rst_s) begin
                     // R06 R09: oscillator restarts so reset can be qualified
                     o_osc_run <= 1'b1;
                  end else if (wake_en && lvl_low) begin
                     o_osc_run <= 1'b1; // R10
                     waking_ff <= 1'b1;
                  end else if (waking_ff) begin
                     // R10 R11: exit completes when pin returns high
                     waking_ff  <= 1'b0;
                     o_mode     <= `PMRC_MODE_RUN;
                     o_pd_req   <= 1'b0; // R17
                     o_idle_req <= 1'b0; // R17
                     o_wake_irq <= 1'b1; // R11
                  end else begin
                     o_osc_run <= 1'b0; // R06
                  end
               end
               `PMRC_MODE_EMU: begin
                  o_osc_run <= 1'b1; // R15
               end
               default: o_mode <= `PMRC_MODE_RUN;
            endcase
            // R17: sets come after the exit clears so a set in the same cycle wins
            if (i_set_idle_req) o_idle_req <= 1'b1;
            if (i_set_pd_req)   o_pd_req   <= 1'b1;
         end
         // R03 R04: cpu gated in idle/pd; state held by the gating, not cleared
         o_cpu_clk_en    <= i_osc_tick & o_osc_run & half_ff & ~o_full_reset &
                            (o_mode == `PMRC_MODE_RUN);
         o_periph_clk_en <= i_osc_tick & o_osc_run & half_ff &
                            (o_mode != `PMRC_MODE_PD); // R04
         // R16 R15: pin states per mode
         o_strobe_force <= (o_mode == `PMRC_MODE_IDLE) | (o_mode == `PMRC_MODE_PD);
         o_addr_strobe_val <= (o_mode != `PMRC_MODE_PD); // R16
         o_program_store_strobe_val <= (o_mode != `PMRC_MODE_PD); // R16
         o_port0_float <= (o_mode == `PMRC_MODE_EMU) |
                          (i_ext_prog_mem & ((o_mode == `PMRC_MODE_IDLE) |
                                             (o_mode == `PMRC_MODE_PD))); // R16 R15
         o_weak_pullup <= (o_mode == `PMRC_MODE_EMU); // R15
         o_port2_addr  <= i_ext_prog_mem & (o_mode == `PMRC_MODE_IDLE); // R16
      end
   end
endmodule // pmrc_top

// ==== verif/pmrc_board.sv ====
`timescale 1ns/1ns
module pmrc_board (
   // clock and oscillator state
   input  wire i_sys_clk,
   input  wire i_osc_run,
   // bench commands
   input  wire i_hold_reset,
   input  wire i_irq_low,
   input  wire i_emu_strap,
   // pins
   output reg  o_osc_tick = 1'b0,
   output wire o_reset_pin,
   output wire o_ext_irq_zero_n,
   output wire o_addr_strobe_pin,
   output wire o_program_store_strobe_pin
);
   // oscillator stands still while stopped
   always @(posedge i_sys_clk) begin
      o_osc_tick <= i_osc_run & ~o_osc_tick;
   end
   assign o_reset_pin = i_hold_reset;
   assign o_ext_irq_zero_n = ~i_irq_low;
   assign o_addr_strobe_pin = ~i_emu_strap;
   assign o_program_store_strobe_pin = 1'b1;
endmodule // pmrc_board

// ==== verif/pmrc_monitor.sv ====
`timescale 1ns/1ns
module pmrc_monitor (
   // clock and reset
   input wire       i_sys_clk,
   input wire       i_rst,
   // watched inputs
   input wire [7:0] i_aux_control_one,
   input wire       i_romless,
   input wire       i_ext_prog_mem,
   input wire       i_instr_done,
   input wire       i_set_idle_req,
   input wire       i_set_pd_req,
   // watched outputs
   input wire       o_idle_req,
   input wire       o_pd_req,
   input wire [1:0] o_mode,
   input wire       o_int_clk_en,
   input wire       o_cpu_clk_en,
   input wire       o_periph_clk_en,
   input wire       o_osc_run,
   input wire       o_full_reset,
   input wire       o_wake_irq,
   input wire       o_addr_strobe_val,
   input wire       o_program_store_strobe_val,
   input wire       o_strobe_force,
   input wire       o_port0_float,
   input wire       o_weak_pullup,
   input wire       o_port2_addr
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   a_pd_stops_osc: assert property ($rose(o_mode == 2'h2) |=> !o_osc_run)
      else $error("osc still running");
   a_idle_pin_state: assert property ((o_mode == 2'h1 && $past(o_mode) == 2'h1) |->
      o_strobe_force && o_addr_strobe_val && o_program_store_strobe_val && !o_cpu_clk_en
      && (o_periph_clk_en == o_int_clk_en)
      && (!i_ext_prog_mem || (o_port0_float && o_port2_addr))) else $error("idle pins wrong");
   a_pd_pin_state: assert property ((o_mode == 2'h2 && $past(o_mode) == 2'h2) |->
      o_strobe_force && !o_addr_strobe_val && !o_program_store_strobe_val
      && (!i_ext_prog_mem || (o_port0_float && !o_port2_addr))) else $error("pd pins wrong");
   a_emu_float_pins: assert property ((o_mode == 2'h3 && $past(o_mode) == 2'h3) |->
      o_port0_float && o_weak_pullup && o_osc_run) else $error("emu pins wrong");
   a_wake_gate: assert property ((o_wake_irq && $past(o_mode) == 2'h2) |->
      $past(i_aux_control_one[3] | i_romless)) else $error("wake not enabled");
   a_wake_exit: assert property (o_wake_irq |->
      o_mode == 2'h0 && (!o_idle_req || $past(i_set_idle_req))
      && (!o_pd_req || $past(i_set_pd_req))) else $error("wake exit wrong");
   a_pd_wins: assert property ((o_mode == 2'h0 && o_pd_req && i_instr_done && !o_full_reset)
      |=> o_mode == 2'h2) else $error("pd not entered");
   // partner ticks every second clock, so the halved clock fires every fourth
   a_clk_half: assert property (o_int_clk_en |=> !o_int_clk_en [*3])
      else $error("clock not halved");
endmodule // pmrc_monitor
bind pmrc_top pmrc_monitor u_pmrc_monitor (.*);

// ==== verif/pmrc_tb_top.sv ====
`timescale 1ns/1ns
module pmrc_tb_top;
   reg        clk = 1'b0, rst = 1'b1, hold = 1'b0, irq_low = 1'b0, strap = 1'b0, lvl = 1'b1;
   reg        s_idle = 1'b0, s_pd = 1'b0, done = 1'b0, pend = 1'b0, ext = 1'b0, rless = 1'b0;
   reg  [7:0] aux = 8'h00;
   integer    errors = 0, samples_checked = 0, seed = 85619, k, n, m, em, wk;
   wire       tick, rpin, irq_n, ale, program_store_strobe, ireq, preq, run, frst, rblk, wake;
   wire       asv, psv, sfor, p0f, wpu, p2a, special_function_registers;
   wire [1:0] mode;
   always #4 clk = ~clk;
   pmrc_board u_pmrc_board (.i_sys_clk(clk), .i_osc_run(run), .i_hold_reset(hold),
      .i_irq_low(irq_low), .i_emu_strap(strap), .o_osc_tick(tick), .o_reset_pin(rpin),
      .o_ext_irq_zero_n(irq_n), .o_addr_strobe_pin(ale), .o_program_store_strobe_pin(program_store_strobe));
   pmrc_top u_pmrc_top (.i_sys_clk(clk), .i_rst(rst), .i_osc_tick(tick), .i_reset_pin(rpin),
      .i_ext_irq_zero_n(irq_n), .i_ext_irq_one_n(1'b1), .i_addr_strobe_pin(ale),
      .i_program_store_strobe_pin(program_store_strobe), .i_irq_zero_en(1'b1), .i_irq_one_en(1'b0),
      .i_irq_zero_level(lvl), .i_irq_one_level(1'b0), .i_aux_control_one(aux),
      .i_romless(rless), .i_ext_prog_mem(ext), .i_any_irq_pending(pend),
      .i_set_idle_req(s_idle), .i_set_pd_req(s_pd), .i_instr_done(done), .o_idle_req(ireq),
      .o_pd_req(preq), .o_mode(mode), .o_int_clk_en(), .o_cpu_clk_en(), .o_periph_clk_en(),
      .o_osc_run(run), .o_full_reset(frst), .o_sfr_reset(special_function_registers), .o_ram_block(rblk),
      .o_wake_irq(wake), .o_addr_strobe_val(asv), .o_program_store_strobe_val(psv),
      .o_strobe_force(sfor), .o_port0_float(p0f), .o_weak_pullup(wpu), .o_port2_addr(p2a));
   task chk(input string what, input [7:0] seen, input [7:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask
   task cyc(input integer c);
      begin
         repeat (c) @(posedge clk);
         #1;
      end
   endtask
   task wait_lo(input integer which);
      begin
         n = 0;
         while (((which == 0) ? frst : !wake) !== 1'b0 && n < 60) begin
            cyc(1);
            n = n + 1;
         end
         if (n >= 60) errors = errors + 1;
      end
   endtask
   // hold the pin for t oscillator ticks, then release
   task pin_reset(input integer t);
      begin
         hold = 1'b1;
         n = 0;
         m = 0;
         while (n < t && m < 400) begin
            cyc(1);
            m = m + 1;
            if (tick === 1'b1) n = n + 1;
         end
         if (m >= 400) errors = errors + 1;
         chk("full reset", {6'h00, special_function_registers, frst}, (t >= 24) ? 8'h03 : 8'h00);
         hold = 1'b0;
         wait_lo(0);
      end
   endtask
   task report_and_stop;
      begin
         $display("errors %0d samples_checked %0d", errors, samples_checked);
         if (errors == 0 && samples_checked > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      #200000;
      errors = errors + 1;
      report_and_stop;
   end
   initial begin
      cyc(3);
      rst = 1'b0;
      wait_lo(0);
      chk("mode after reset", {6'h00, mode}, 8'h00);
      pin_reset(12);
      for (k = 0; k < 6; k = k + 1) begin
         ext = $random(seed);
         aux = ($random(seed) & ((k == 1) ? 8'hF7 : 8'hFF)) | ((k == 4) ? 8'h08 : 8'h00);
         rless = (k == 5);
         lvl = (k != 2);
         wk = (aux[3] | rless) & lvl;
         s_idle = (k % 3 != 1);
         s_pd = (k % 3 != 0);
         cyc(1);
         s_idle = 1'b0;
         s_pd = 1'b0;
         cyc(1);
         done = 1'b1;
         cyc(1);
         done = 1'b0;
         cyc(2);
         em = (k % 3 == 0) ? 1 : 2;
         chk("mode entered", {6'h00, mode}, em);
         chk("strobes", {sfor, asv, psv, p0f}, (em == 1) ? {3'h7, ext} : {3'h4, ext});
         chk("port2 address", {7'h00, p2a}, (em == 1) ? ext : 1'b0);
         if (em == 1 && k == 3) begin
            hold = 1'b1;
            cyc(10);
            chk("ram block", {7'h00, rblk}, 8'h01);
            pin_reset(40);
            chk("mode after reset", {6'h00, mode}, 8'h00);
            chk("ram block released", {7'h00, rblk}, 8'h00);
         end else if (em == 1) begin
            pend = 1'b1;
            cyc(1);
            pend = 1'b0;
            wait_lo(1);
            chk("idle exit", {5'h00, wake, mode}, 8'h04);
            chk("request bits", {ireq, preq}, 8'h00);
         end else begin
            chk("osc stopped", {7'h00, run}, 8'h00);
            irq_low = 1'b1;
            cyc(12);
            chk("osc restart", {7'h00, run}, (wk != 0) ? 8'h01 : 8'h00);
            irq_low = 1'b0;
            if (wk != 0) begin
               wait_lo(1);
               chk("wake exit", {5'h00, wake, mode}, 8'h04);
            end else begin
               cyc(8);
               chk("wake refused", {6'h00, mode}, 8'h02);
               pin_reset(40);
               chk("mode after reset", {6'h00, mode}, 8'h00);
            end
         end
         cyc(4);
      end
      rst = 1'b1;
      strap = 1'b1;
      cyc(3);
      rst = 1'b0;
      wait_lo(0);
      chk("mode after mid-run reset", {6'h00, mode}, 8'h00);
      pin_reset(40);
      strap = 1'b0;
      cyc(3);
      chk("emulation", {5'h00, wpu, mode}, 8'h07);
      pin_reset(40);
      chk("emulation left", {6'h00, mode}, 8'h00);
      report_and_stop;
   end
endmodule // pmrc_tb_top
